// *** common/rblpc_pkg.sv ***
// shared constants, types and functions of the breathing led pwm controller
package rblpc_pkg;
	// ====================
	// register offsets
	localparam logic [7:0] A_SHUTDOWN = 8'h00;
	localparam logic [7:0] A_BREATH = 8'h01;
	localparam logic [7:0] A_MODE = 8'h02;
	localparam logic [7:0] A_CURRENT = 8'h03;
	localparam logic [7:0] A_DUTY0 = 8'h04;
	localparam logic [7:0] A_PWM_UPD = 8'h07;
	localparam logic [7:0] A_DELAY0 = 8'h0a;
	localparam logic [7:0] A_RISEHOLD0 = 8'h10;
	localparam logic [7:0] A_FALLOFF0 = 8'h16;
	localparam logic [7:0] A_TIME_UPD = 8'h1c;
	localparam logic [7:0] A_ON_OFF = 8'h1d;
	localparam logic [7:0] A_SW_RESET = 8'h2f;
	localparam logic [7:0] BANK_SIZE = 8'h03;
	// value that fires the update and reset triggers
	localparam logic [7:0] TRIGGER_KEY = 8'h00;
	// ====================
	// field positions and masks
	localparam int SOFT_OFF_BIT = 0;
	localparam int EN_BIT = 5;
	localparam int HOLD_SEL_BIT = 4;
	localparam int RAMP_BIT = 5;
	localparam int BREATH_BIT = 5;
	localparam int CS_LSB = 2;
	localparam int DELAY_LSB = 4;
	localparam int RISE_LSB = 5;
	localparam int HOLD_LSB = 1;
	localparam logic [7:0] SHUT_MASK = 8'h21;
	localparam logic [7:0] BREATH_MASK = 8'h30;
	localparam logic [7:0] MODE_MASK = 8'h20;
	localparam logic [7:0] CURRENT_MASK = 8'h1c;
	// ====================
	// reset values
	localparam logic [7:0] SHUT_RST = 8'h01;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [7:0] TIME_RST = 8'h00;
	localparam logic [2:0] ON_RST = 3'h7;
	// ====================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_PERIOD_NS = 130_000_000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned STEPS_PER_TICK = 256;
	localparam logic [3:0] DELAY_MAX = 4'ha;
	localparam logic [3:0] HOLD_MAX = 4'h8;
	localparam logic [3:0] OFF_MAX = 4'ha;
	// ====================
	// sequencer phases
	typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_RISE, ST_HOLD, ST_FALL, ST_OFF} rblpc_phase_t;
	// code 0 is zero ticks, then doubling from one tick; unavailable codes give zero
	function automatic logic [9:0] doubling_ticks(input logic [3:0] code, input logic [3:0] max_code);
		logic [9:0] t;
		t = 10'h000;
		if (code != 4'h0 && code <= max_code)
			t = 10'h001 << (code - 4'h1);
		return t;
	endfunction : doubling_ticks
endpackage : rblpc_pkg

// *** hdl/rblpc_step_gen.sv ***
// fine step strobe that subdivides the phase tick
`timescale 1ns/100ps
module rblpc_step_gen #(
	parameter int unsigned STEP_CYCLES = 50_781
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	output logic step_o
);
	// ====================
	// elaboration check
	if (STEP_CYCLES < 2)
	begin : g_bad_step
		$error("STEP_CYCLES must be at least 2");
	end
	logic [31:0] count; // cycles since last step
	// free-running divider, one-cycle pulse at the wrap
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			count <= 32'h0;
			step_o <= 1'b0;
		end
		else if (count == 32'(STEP_CYCLES - 1))
		begin
			count <= 32'h0;
			step_o <= 1'b1;
		end
		else
		begin
			count <= count + 32'h1;
			step_o <= 1'b0;
		end
	end
endmodule : rblpc_step_gen

// *** hdl/rblpc_channel.sv ***
// one output channel: breathing sequencer, intensity and pwm compare
`timescale 1ns/100ps
module rblpc_channel (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic step_i,
	input wire logic run_i,
	input wire logic restart_i,
	input wire logic breath_i,
	input wire logic ramp_i,
	input wire logic hold_sel_i,
	input wire logic gate_i,
	input wire logic [7:0] peak_i,
	input wire logic [7:0] pwm_cnt_i,
	input wire logic [3:0] delay_code_i,
	input wire logic [2:0] rise_code_i,
	input wire logic [3:0] hold_code_i,
	input wire logic [2:0] fall_code_i,
	input wire logic [3:0] off_code_i,
	output logic channel_output_o
);
	rblpc_pkg::rblpc_phase_t state; // current phase
	logic [17:0] elapsed; // steps spent in the phase
	logic [17:0] cur_len; // phase length in steps
	logic done; // phase ends this cycle
	logic [7:0] progress; // ramp position 0..255
	logic [15:0] scaled; // peak times progress
	logic [7:0] level; // effective intensity
	// ====================
	// phase length: ticks times 256 steps
	always_comb
	begin
		case (state)
			rblpc_pkg::ST_DELAY:
				cur_len = {rblpc_pkg::doubling_ticks(delay_code_i, rblpc_pkg::DELAY_MAX), 8'h00};
			rblpc_pkg::ST_RISE: cur_len = {10'h001 << rise_code_i, 8'h00};
			rblpc_pkg::ST_HOLD:
				cur_len = {rblpc_pkg::doubling_ticks(hold_code_i, rblpc_pkg::HOLD_MAX), 8'h00};
			rblpc_pkg::ST_FALL: cur_len = {10'h001 << fall_code_i, 8'h00};
			rblpc_pkg::ST_OFF:
				cur_len = {rblpc_pkg::doubling_ticks(off_code_i, rblpc_pkg::OFF_MAX), 8'h00};
			default: cur_len = 18'h0;
		endcase
	end
	// zero-length phases pass in a single cycle
	assign done = (cur_len == 18'h0) || (step_i && elapsed == cur_len - 18'h1);
	// ====================
	// step counter, cleared at each phase boundary
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || !run_i || restart_i || done)
			elapsed <= 18'h0;
		else if (step_i)
			elapsed <= elapsed + 18'h1;
	end
	// phase sequencer; delay is entered only from idle
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || !run_i || restart_i)
			state <= rblpc_pkg::ST_IDLE;
		else
		begin
			case (state)
				rblpc_pkg::ST_IDLE: state <= rblpc_pkg::ST_DELAY;
				rblpc_pkg::ST_DELAY: if (done) state <= rblpc_pkg::ST_RISE;
				rblpc_pkg::ST_RISE: if (done) state <= rblpc_pkg::ST_HOLD;
				rblpc_pkg::ST_HOLD: if (done && !(ramp_i && !hold_sel_i)) state <= rblpc_pkg::ST_FALL;
				rblpc_pkg::ST_FALL: if (done) state <= rblpc_pkg::ST_OFF;
				rblpc_pkg::ST_OFF: if (done && !(ramp_i && hold_sel_i)) state <= rblpc_pkg::ST_RISE;
				default: state <= rblpc_pkg::ST_IDLE;
			endcase
		end
	end
	// ====================
	// intensity: linear ramps, peak taken from the duty value
	assign progress = (state == rblpc_pkg::ST_FALL) ? ~8'(elapsed >> fall_code_i) : 8'(elapsed >> rise_code_i);
	assign scaled = peak_i * progress;
	always_comb
	begin
		if (!breath_i)
			level = peak_i;
		else if (state == rblpc_pkg::ST_HOLD)
			level = peak_i;
		else if (state == rblpc_pkg::ST_RISE || state == rblpc_pkg::ST_FALL)
			level = scaled[15:8];
		else
			level = 8'h00;
	end
	// output is registered so the pin never glitches
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			channel_output_o <= 1'b0;
		else
			channel_output_o <= gate_i && (pwm_cnt_i < level);
	end
	// ====================
	// checks
	direct_on_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(!breath_i && gate_i && pwm_cnt_i < peak_i) |=> channel_output_o)
		else $error("direct pwm slot missing");
	never_above_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(pwm_cnt_i >= peak_i) |=> !channel_output_o)
		else $error("output active above peak");
	delay_once_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state == rblpc_pkg::ST_DELAY && $past(state) != rblpc_pkg::ST_DELAY) |-> $past(state) == rblpc_pkg::ST_IDLE)
		else $error("delay entered mid cycle");
	cycle_back_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state == rblpc_pkg::ST_OFF && done && run_i && !restart_i && !ramp_i) |=> state == rblpc_pkg::ST_RISE)
		else $error("breathing did not repeat");
	peak_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(breath_i && state == rblpc_pkg::ST_HOLD && gate_i && pwm_cnt_i < peak_i) |=> channel_output_o)
		else $error("hold not at peak");
	park_peak_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state == rblpc_pkg::ST_HOLD && run_i && !restart_i && ramp_i && !hold_sel_i) |=> state == rblpc_pkg::ST_HOLD)
		else $error("ramp left hold");
	park_dark_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(state == rblpc_pkg::ST_OFF && run_i && !restart_i && ramp_i && hold_sel_i) |=> state == rblpc_pkg::ST_OFF)
		else $error("ramp left off phase");
	step_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(step_i && !done && run_i && !restart_i) |=> elapsed == $past(elapsed) + 18'h1)
		else $error("phase counter missed a step");
endmodule : rblpc_channel

// *** hdl/rblpc_controller.sv ***
// top of the breathing led pwm controller: registers, shutdown and channels
`timescale 1ns/100ps
module rblpc_controller #(
	parameter int unsigned TICK_CYCLES = rblpc_pkg::TICK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic wr_strobe_i,
	input wire logic [7:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic hw_shutdown_n_i,
	output logic [2:0] channel_output_o,
	output logic [2:0] current_setting_o
);
	// ====================
	// derived timing
	// 256 fine steps per tick; the remainder is dropped, so a tick runs
	// a few cycles short of its nominal length
	localparam int unsigned STEP_CYCLES = TICK_CYCLES / rblpc_pkg::STEPS_PER_TICK;
	if (TICK_CYCLES < 2 * rblpc_pkg::STEPS_PER_TICK)
	begin : g_bad_tick
		$error("TICK_CYCLES too small for 256 steps");
	end

	// ====================
	// bank decode helpers
	// address falls within a three-register channel bank
	function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base);
		return (addr >= base) && (addr < base + rblpc_pkg::BANK_SIZE);
	endfunction : in_bank

	// channel index within a bank
	function automatic logic [1:0] chan_of(input logic [7:0] addr, input logic [7:0] base);
		logic [7:0] d;
		d = addr - base;
		return d[1:0];
	endfunction : chan_of

	// ====================
	// shutdown pin synchroniser
	logic hw_meta; // first stage, read only by hw_on
	logic hw_on; // synchronised pin, high = running

	// two flops; held low in reset so outputs start dark
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			hw_meta <= 1'b0;
			hw_on <= 1'b0;
		end
		else
		begin
			hw_meta <= hw_shutdown_n_i;
			hw_on <= hw_meta;
		end
	end

	// ====================
	// write triggers
	logic wr_key; // a write carrying the trigger value
	logic sw_reset; // restores every host register
	logic pwm_update; // loads duty and on bits
	logic time_update; // loads timing fields

	assign wr_key = wr_strobe_i && (wr_data_i == rblpc_pkg::TRIGGER_KEY);
	assign sw_reset = wr_key && (wr_addr_i == rblpc_pkg::A_SW_RESET);
	assign pwm_update = wr_key && (wr_addr_i == rblpc_pkg::A_PWM_UPD);
	assign time_update = wr_key && (wr_addr_i == rblpc_pkg::A_TIME_UPD);

	// ====================
	// control registers
	logic [7:0] shutdown; // soft shutdown and all-channel enable
	logic [7:0] breath_ctl; // ramp enable and hold select
	logic [7:0] mode; // breathing mode select
	logic [7:0] current; // current level for the analog side

	// written directly; only defined bits are kept, the rest stay zero
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || sw_reset)
		begin
			shutdown <= rblpc_pkg::SHUT_RST;
			breath_ctl <= rblpc_pkg::CTRL_RST;
			mode <= rblpc_pkg::CTRL_RST;
			current <= rblpc_pkg::CTRL_RST;
		end
		else if (wr_strobe_i)
		begin
			if (wr_addr_i == rblpc_pkg::A_SHUTDOWN)
				shutdown <= wr_data_i & rblpc_pkg::SHUT_MASK;
			else if (wr_addr_i == rblpc_pkg::A_BREATH)
				breath_ctl <= wr_data_i & rblpc_pkg::BREATH_MASK;
			else if (wr_addr_i == rblpc_pkg::A_MODE)
				mode <= wr_data_i & rblpc_pkg::MODE_MASK;
			else if (wr_addr_i == rblpc_pkg::A_CURRENT)
				current <= wr_data_i & rblpc_pkg::CURRENT_MASK;
		end
	end

	// the current code goes straight to the analog current sources
	assign current_setting_o = current[rblpc_pkg::CS_LSB +: 3];

	// ====================
	// duty and on bits: staged copy
	logic [7:0] duty_stage [3]; // written by the host
	logic [2:0] on_stage; // written by the host
	logic [7:0] duty_act [3]; // drives the channels
	logic [2:0] on_act; // drives the channels

	// staging registers take host writes at once
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || sw_reset)
		begin
			for (int i = 0; i < 3; i++)
				duty_stage[i] <= rblpc_pkg::DUTY_RST;
			on_stage <= rblpc_pkg::ON_RST;
		end
		else if (wr_strobe_i)
		begin
			if (in_bank(wr_addr_i, rblpc_pkg::A_DUTY0))
				duty_stage[chan_of(wr_addr_i, rblpc_pkg::A_DUTY0)] <= wr_data_i;
			else if (wr_addr_i == rblpc_pkg::A_ON_OFF)
				on_stage <= wr_data_i[2:0];
		end
	end

	// active copy moves only on the pwm update trigger or a software reset
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || sw_reset)
		begin
			for (int i = 0; i < 3; i++)
				duty_act[i] <= rblpc_pkg::DUTY_RST;
			on_act <= rblpc_pkg::ON_RST;
		end
		else if (pwm_update)
		begin
			for (int i = 0; i < 3; i++)
				duty_act[i] <= duty_stage[i];
			on_act <= on_stage;
		end
	end

	// ====================
	// timing fields: staged copy
	logic [7:0] delay_stage [3]; // start delay per channel
	logic [7:0] rh_stage [3]; // rise and hold-high per channel
	logic [7:0] fo_stage [3]; // fall and off per channel
	logic [7:0] delay_act [3];
	logic [7:0] rh_act [3];
	logic [7:0] fo_act [3];

	// staging registers for the three timing banks
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || sw_reset)
		begin
			for (int i = 0; i < 3; i++)
			begin
				delay_stage[i] <= rblpc_pkg::TIME_RST;
				rh_stage[i] <= rblpc_pkg::TIME_RST;
				fo_stage[i] <= rblpc_pkg::TIME_RST;
			end
		end
		else if (wr_strobe_i)
		begin
			if (in_bank(wr_addr_i, rblpc_pkg::A_DELAY0))
				delay_stage[chan_of(wr_addr_i, rblpc_pkg::A_DELAY0)] <= wr_data_i;
			else if (in_bank(wr_addr_i, rblpc_pkg::A_RISEHOLD0))
				rh_stage[chan_of(wr_addr_i, rblpc_pkg::A_RISEHOLD0)] <= wr_data_i;
			else if (in_bank(wr_addr_i, rblpc_pkg::A_FALLOFF0))
				fo_stage[chan_of(wr_addr_i, rblpc_pkg::A_FALLOFF0)] <= wr_data_i;
		end
	end

	// all three channels take new timing together
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i || sw_reset)
		begin
			for (int i = 0; i < 3; i++)
			begin
				delay_act[i] <= rblpc_pkg::TIME_RST;
				rh_act[i] <= rblpc_pkg::TIME_RST;
				fo_act[i] <= rblpc_pkg::TIME_RST;
			end
		end
		else if (time_update)
		begin
			for (int i = 0; i < 3; i++)
			begin
				delay_act[i] <= delay_stage[i];
				rh_act[i] <= rh_stage[i];
				fo_act[i] <= fo_stage[i];
			end
		end
	end

	// ====================
	// shared pwm counter and step base
	logic [7:0] pwm_cnt; // free-running 256-slot frame
	logic step; // fine step strobe

	// one pwm frame every 256 clocks for all channels
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			pwm_cnt <= 8'h00;
		else
			pwm_cnt <= pwm_cnt + 8'h01;
	end

	rblpc_step_gen #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_step (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.step_o(step)
	);

	// ====================
	// channels
	logic [2:0] gate; // channel allowed to light
	logic [2:0] run; // sequencer allowed to advance

	// shutdown gates outputs and sends the sequencers back to idle; no host register is touched by it
	// enable set, soft shutdown clear and pin high must all hold together
	assign gate = on_act & {3{shutdown[rblpc_pkg::EN_BIT]
		&& !shutdown[rblpc_pkg::SOFT_OFF_BIT] && hw_on}};
	// a gated channel restarts its sequence from the delay once released
	assign run = gate & {3{mode[rblpc_pkg::BREATH_BIT]}};

	for (genvar g = 0; g < 3; g++)
	begin : g_ch
		rblpc_channel u_ch (
			.mclk_i(mclk_i),
			.rst_n_i(rst_n_i),
			.step_i(step),
			.run_i(run[g]),
			.restart_i(time_update),
			.breath_i(mode[rblpc_pkg::BREATH_BIT]),
			.ramp_i(breath_ctl[rblpc_pkg::RAMP_BIT]),
			.hold_sel_i(breath_ctl[rblpc_pkg::HOLD_SEL_BIT]),
			.gate_i(gate[g]),
			.peak_i(duty_act[g]),
			.pwm_cnt_i(pwm_cnt),
			.delay_code_i(delay_act[g][rblpc_pkg::DELAY_LSB +: 4]),
			.rise_code_i(rh_act[g][rblpc_pkg::RISE_LSB +: 3]),
			.hold_code_i(rh_act[g][rblpc_pkg::HOLD_LSB +: 4]),
			.fall_code_i(fo_act[g][rblpc_pkg::RISE_LSB +: 3]),
			.off_code_i(fo_act[g][rblpc_pkg::HOLD_LSB +: 4]),
			.channel_output_o(channel_output_o[g])
		);
	end

	// ====================
	// checks
	time_stage_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(!time_update && !sw_reset) |=> $stable(delay_act[0]) && $stable(rh_act[1]) && $stable(fo_act[2]))
		else $error("timing moved without update");
	duty_stage_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(!pwm_update && !sw_reset) |=> $stable(duty_act[1]) && $stable(on_act))
		else $error("duty moved without update");
	sw_reset_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		sw_reset |=> shutdown == rblpc_pkg::SHUT_RST && on_stage == rblpc_pkg::ON_RST
			&& duty_act[2] == rblpc_pkg::DUTY_RST && mode == rblpc_pkg::CTRL_RST)
		else $error("software reset incomplete");
	power_up_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> channel_output_o == 3'h0 && on_act == rblpc_pkg::ON_RST)
		else $error("not dark after reset");
	soft_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		shutdown[rblpc_pkg::SOFT_OFF_BIT] |=> channel_output_o == 3'h0)
		else $error("lit in soft shutdown");
	pin_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!hw_shutdown_n_i [*3] |=> channel_output_o == 3'h0)
		else $error("lit in hardware shutdown");
	chan_mask_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		1'b1 |=> (channel_output_o & ~$past(on_act)) == 3'h0)
		else $error("disabled channel lit");
	all_en_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!shutdown[rblpc_pkg::EN_BIT] |=> channel_output_o == 3'h0)
		else $error("lit with enable clear");
	keep_regs_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!wr_strobe_i |=> $stable(shutdown) && $stable(mode) && $stable(duty_stage[0]))
		else $error("register changed without write");
endmodule : rblpc_controller

// *** bench/rblpc_host_model.sv ***
// host model that writes configuration bytes into the controller
`timescale 1ns/100ps
module rblpc_host_model (
	input wire logic mclk_i,
	output logic wr_strobe_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o
);
	// ====================
	// idle bus at time zero
	initial
	begin
		wr_strobe_o = 1'b0;
		wr_addr_o = 8'hff;
		wr_data_o = 8'h00;
	end
	// ====================
	// one byte per call, raised and dropped on falling edges
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		wr_strobe_o = 1'b1;
		wr_addr_o = a;
		wr_data_o = d;
		@(negedge mclk_i);
		wr_strobe_o = 1'b0;
		// released bus shows the inverse, so a stale byte cannot pass for a live one
		wr_addr_o = ~a;
		wr_data_o = ~d;
	endtask : put
	// new brightness only by rewriting the duty bytes
	task automatic set_duty(input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2);
		put(rblpc_pkg::A_DUTY0, d0);
		put(rblpc_pkg::A_DUTY0 + 8'h01, d1);
		put(rblpc_pkg::A_DUTY0 + 8'h02, d2);
	endtask : set_duty
	// same phase times on every channel so a mixed colour holds
	task automatic set_times(input logic [7:0] dly, input logic [7:0] rh, input logic [7:0] fo);
		for (int g = 0; g < 3; g++)
		begin
			put(rblpc_pkg::A_DELAY0 + 8'(g), dly);
			put(rblpc_pkg::A_RISEHOLD0 + 8'(g), rh);
			put(rblpc_pkg::A_FALLOFF0 + 8'(g), fo);
		end
	endtask : set_times
endmodule : rblpc_host_model

// *** bench/rblpc_controller_bench.sv ***
// self-checking bench of the breathing led pwm controller
`timescale 1ns/100ps
module rblpc_controller_bench;
	// ====================
	// clock, reset, pin and bus
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hw_shutdown_n_i = 1'b1; // pin high: running
	logic wr_strobe;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [2:0] chan_out;
	logic [2:0] cur_set;
	int fail_count = 0;
	int n_tests = 0;
	int n;
	always #5 mclk_i = ~mclk_i;
	// ====================
	// design and host; short tick keeps the run brief (one tick = 512 clocks)
	rblpc_controller #(.TICK_CYCLES(512)) i_dut (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.wr_strobe_i(wr_strobe),
		.wr_addr_i(wr_addr),
		.wr_data_i(wr_data),
		.hw_shutdown_n_i(hw_shutdown_n_i),
		.channel_output_o(chan_out),
		.current_setting_o(cur_set)
	);
	rblpc_host_model i_host (
		.mclk_i(mclk_i),
		.wr_strobe_o(wr_strobe),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data)
	);
	// ====================
	// compare helpers
	task automatic check(input int got, input int exp, input string what);
		n_tests++;
		if (got != exp)
		begin
			fail_count++;
			$display("unexpected at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask : check
	task automatic chk_cur(input logic [2:0] e);
		@(negedge mclk_i);
		n_tests++;
		if (cur_set !== e)
		begin
			fail_count++;
			$display("unexpected at %0t: current code %b", $time, cur_set);
		end
	endtask : chk_cur
	// high slots per channel over one 256-clock frame; an unknown adds 1000 so the check fails
	task automatic frame(input int e0, input int e1, input int e2);
		int c [3];
		c = '{0, 0, 0};
		repeat (4) @(negedge mclk_i);
		repeat (256)
		begin
			@(negedge mclk_i);
			for (int g = 0; g < 3; g++)
				c[g] += (chan_out[g] === 1'b1) ? 1 : ((chan_out[g] === 1'b0) ? 0 : 1000);
		end
		check(c[0], e0, "ch0 slots");
		check(c[1], e1, "ch1 slots");
		check(c[2], e2, "ch2 slots");
	endtask : frame
	// ====================
	// verdict, reached from the tests or the watchdog
	task automatic test_done;
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	// watchdog: the tests need roughly 13.4k clocks
	initial
	begin
		#(60_000 * 10);
		fail_count++;
		test_done();
	end
	// ====================
	// main sequence
	initial
	begin
		repeat (2) @(negedge mclk_i);
		rst_n_i = 1'b1;
		frame(0, 0, 0);
		chk_cur(3'h0);
		// direct pwm, staged duty
		i_host.put(rblpc_pkg::A_SHUTDOWN, 8'h20);
		i_host.set_duty(8'h04, 8'h80, 8'hff);
		frame(0, 0, 0);
		i_host.put(rblpc_pkg::A_PWM_UPD, 8'h01);
		i_host.put(8'h08, 8'hff); // unmapped offset
		frame(0, 0, 0);
		i_host.put(rblpc_pkg::A_PWM_UPD, 8'h00);
		frame(4, 128, 255);
		// on bits staged too
		i_host.put(rblpc_pkg::A_ON_OFF, 8'h05);
		frame(4, 128, 255);
		i_host.put(rblpc_pkg::A_PWM_UPD, 8'h00);
		frame(4, 0, 255);
		// soft shutdown and enable bit
		i_host.put(rblpc_pkg::A_SHUTDOWN, 8'h21);
		frame(0, 0, 0);
		i_host.put(rblpc_pkg::A_SHUTDOWN, 8'h00);
		frame(0, 0, 0);
		i_host.put(rblpc_pkg::A_SHUTDOWN, 8'h20);
		frame(4, 0, 255);
		// pin shutdown, synchroniser needs a few clocks
		hw_shutdown_n_i = 1'b0;
		repeat (6) @(negedge mclk_i);
		frame(0, 0, 0);
		hw_shutdown_n_i = 1'b1;
		repeat (6) @(negedge mclk_i);
		frame(4, 0, 255);
		i_host.put(rblpc_pkg::A_CURRENT, 8'hff);
		chk_cur(3'h7);
		// ramp and hold at peak
		i_host.put(rblpc_pkg::A_ON_OFF, 8'h07);
		i_host.put(rblpc_pkg::A_PWM_UPD, 8'h00);
		i_host.put(rblpc_pkg::A_BREATH, 8'h20);
		i_host.put(rblpc_pkg::A_MODE, 8'h20);
		repeat (1200) @(negedge mclk_i);
		frame(4, 128, 255);
		// staged start delay of code 3: four ticks
		i_host.set_times(8'h30, 8'h00, 8'h00);
		frame(4, 128, 255);
		i_host.put(rblpc_pkg::A_TIME_UPD, 8'h05);
		frame(4, 128, 255);
		i_host.put(rblpc_pkg::A_TIME_UPD, 8'h00);
		repeat (1500) @(negedge mclk_i);
		frame(0, 0, 0);
		repeat (1100) @(negedge mclk_i);
		frame(4, 128, 255);
		// hold select: one fall, then parked dark
		i_host.put(rblpc_pkg::A_BREATH, 8'h30);
		repeat (1500) @(negedge mclk_i);
		frame(0, 0, 0);
		// free cycling never repeats the delay, so no window is dark
		i_host.put(rblpc_pkg::A_BREATH, 8'h00);
		repeat (6)
		begin
			n = 0;
			repeat (512)
			begin
				@(negedge mclk_i);
				n += (chan_out[2] === 1'b1) ? 1 : 0;
			end
			check((n > 0) ? 1 : 0, 1, "breath cycling");
		end
		// software reset
		i_host.put(rblpc_pkg::A_SW_RESET, 8'h01);
		chk_cur(3'h7);
		i_host.put(rblpc_pkg::A_SW_RESET, 8'h00);
		chk_cur(3'h0);
		frame(0, 0, 0);
		i_host.put(rblpc_pkg::A_SHUTDOWN, 8'h20);
		i_host.put(rblpc_pkg::A_PWM_UPD, 8'h00);
		frame(0, 0, 0);
		test_done();
	end
endmodule : rblpc_controller_bench
